// ### lds_limit_chan.sv
`timescale 1ns/1ps
`default_nettype none
module lds_limit_chan #(
    parameter int W = 8
) (
    input  wire logic         i_output_on,
    input  wire logic         i_own_mode,
    input  wire logic         i_full_en,
    input  wire logic         i_code_en,
    input  wire logic         i_fix_en,
    input  wire logic [W-1:0] i_off_code,
    input  wire logic [W-1:0] i_on_code,
    input  wire logic [W-1:0] i_setpoint,
    output logic      [W-1:0] o_code
);
    logic [W-1:0] off_value;
    logic [W-1:0] on_value;
    logic         full_hit;

    // Full scale only in the channel's own regulation mode
    assign full_hit  = i_own_mode & i_full_en;
    assign off_value = full_hit  ? W'(lds_pkg::DAC_FULL) :
                       i_code_en ? i_off_code :
                                   W'(lds_pkg::DAC_ZERO);
    // Fixed on-state limit applies while the other channel regulates
    assign on_value  = (!i_own_mode && i_fix_en) ? i_on_code : i_setpoint;
    assign o_code    = i_output_on ? on_value : off_value;
endmodule
`default_nettype wire

// ### lds_limit_dac_code_selector.sv
// How it works
// - Off, voltage mode: current DAC gets off code
// - Off, current mode: voltage DAC gets off code
// - On, voltage mode: current DAC fixed code
// - On, current mode: voltage DAC fixed code
// - Queries return the stored byte
// - Four stored limit codes reset to zero
// - Select zero: both DACs zero when off
// - Select bit 0: voltage full scale when off in voltage mode
// - Select bit 1: current full scale when off in current mode
// - Select bit 2: voltage stored off code
// - Select bit 3: current stored off code
// - Full scale wins over stored code
// - Sanitize clears the select register
// - Select register is one hex nibble
// - Save copies setup to nonvolatile store
// - Current error bit 7 fixes current limit when on in voltage mode
// - Voltage error bit 7 fixes voltage limit when on in current mode
`timescale 1ns/1ps
`default_nettype none
module lds_limit_dac_code_selector #(
    parameter int W = lds_pkg::CODE_W
) (
    input  wire logic               i_clk_sys,
    input  wire logic               i_reset,
    input  wire lds_pkg::lds_cmd_t  i_cmd,
    input  wire logic               i_output_on,
    input  wire logic               i_current_mode,
    input  wire logic [W-1:0]       i_volt_setpoint,
    input  wire logic [W-1:0]       i_curr_setpoint,
    output logic      [W-1:0]       o_dac_volt,
    output logic      [W-1:0]       o_dac_curr,
    output logic                    o_rsp_valid,
    output logic                    o_rsp_error,
    output logic      [7:0]         o_rsp_data,
    output logic                    o_nv_save,
    output lds_pkg::lds_setup_t     o_nv_image
);
    lds_pkg::lds_setup_t setup_q;
    lds_pkg::lds_setup_t setup_d;
    logic [W-1:0]        dac_volt_q;
    logic [W-1:0]        dac_curr_q;
    logic [W-1:0]        volt_code;
    logic [W-1:0]        curr_code;
    logic                rsp_valid_q;
    logic                rsp_error_q;
    logic [7:0]          rsp_data_q;
    logic                nv_save_q;
    lds_pkg::lds_setup_t nv_image_q;

    logic       is_write;
    logic       is_query;
    logic       is_sanitize;
    logic       is_save;
    logic       known_query;
    logic [7:0] query_value;

    assign is_write    = i_cmd.valid & ~i_cmd.query;
    assign is_query    = i_cmd.valid & i_cmd.query;
    assign is_sanitize = is_write & (i_cmd.code == lds_pkg::CMD_SANITIZE);
    assign is_save     = is_write & (i_cmd.code == lds_pkg::CMD_SAVE);

    // Stored setup: one command per cycle, so no write collides
    always_comb begin
        setup_d = setup_q;
        if (is_write) begin
            case (i_cmd.code)
                lds_pkg::CMD_OFF_CURR: setup_d.off_curr = i_cmd.data;
                lds_pkg::CMD_OFF_VOLT: setup_d.off_volt = i_cmd.data;
                lds_pkg::CMD_ON_CURR:  setup_d.on_curr  = i_cmd.data;
                lds_pkg::CMD_ON_VOLT:  setup_d.on_volt  = i_cmd.data;
                // Select nibble: upper data bits are dropped
                // one hex nibble
                lds_pkg::CMD_SELECT:   setup_d.select   = i_cmd.data[3:0];
                lds_pkg::CMD_ERR_CURR: setup_d.err_curr = i_cmd.data;
                lds_pkg::CMD_ERR_VOLT: setup_d.err_volt = i_cmd.data;
                lds_pkg::CMD_SANITIZE: setup_d.select   =
                                           lds_pkg::SELECT_RESET;
                default:               setup_d = setup_q;
            endcase
        end
    end

    always_comb begin
        known_query = 1'b1;
        query_value = 8'h00;
        case (i_cmd.code)
            lds_pkg::CMD_OFF_CURR: query_value = setup_q.off_curr;
            lds_pkg::CMD_OFF_VOLT: query_value = setup_q.off_volt;
            lds_pkg::CMD_ON_CURR:  query_value = setup_q.on_curr;
            lds_pkg::CMD_ON_VOLT:  query_value = setup_q.on_volt;
            lds_pkg::CMD_SELECT:   query_value = {lds_pkg::NIBBLE_ZERO,
                                                  setup_q.select};
            lds_pkg::CMD_ERR_CURR: query_value = setup_q.err_curr;
            lds_pkg::CMD_ERR_VOLT: query_value = setup_q.err_volt;
            default:               known_query = 1'b0;
        endcase
    end

    // Voltage channel regulates in voltage mode
    // voltage limit choice
    lds_limit_chan #(
        .W (W)
    ) u_volt_chan (
        .i_output_on (i_output_on),
        .i_own_mode  (~i_current_mode),
        .i_full_en   (setup_q.select[lds_pkg::SEL_VOLT_FULL_BIT]),
        .i_code_en   (setup_q.select[lds_pkg::SEL_VOLT_CODE_BIT]),
        .i_fix_en    (setup_q.err_volt[lds_pkg::ERR_FIX_BIT]),
        .i_off_code  (setup_q.off_volt),
        .i_on_code   (setup_q.on_volt),
        .i_setpoint  (i_volt_setpoint),
        .o_code      (volt_code)
    );

    // Current off code enabled by select bit 3 of the nibble
    // current limit choice
    lds_limit_chan #(
        .W (W)
    ) u_curr_chan (
        .i_output_on (i_output_on),
        .i_own_mode  (i_current_mode),
        .i_full_en   (setup_q.select[lds_pkg::SEL_CURR_FULL_BIT]),
        .i_code_en   (setup_q.select[lds_pkg::SEL_CURR_CODE_BIT]),
        .i_fix_en    (setup_q.err_curr[lds_pkg::ERR_FIX_BIT]),
        .i_off_code  (setup_q.off_curr),
        .i_on_code   (setup_q.on_curr),
        .i_setpoint  (i_curr_setpoint),
        .o_code      (curr_code)
    );

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            setup_q <= '{off_curr: lds_pkg::CODE_RESET,
                         off_volt: lds_pkg::CODE_RESET,
                         on_curr:  lds_pkg::CODE_RESET,
                         on_volt:  lds_pkg::CODE_RESET,
                         select:   lds_pkg::SELECT_RESET,
                         err_curr: lds_pkg::ERR_RESET,
                         err_volt: lds_pkg::ERR_RESET};
        end else begin
            setup_q <= setup_d;
        end
    end

    // DAC codes registered so the converters never see a glitch
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            dac_volt_q <= W'(lds_pkg::DAC_ZERO);
            dac_curr_q <= W'(lds_pkg::DAC_ZERO);
        end else begin
            dac_volt_q <= volt_code;
            dac_curr_q <= curr_code;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            rsp_valid_q <= 1'b0;
            rsp_error_q <= 1'b0;
            rsp_data_q  <= 8'h00;
        end else begin
            rsp_valid_q <= is_query;
            rsp_error_q <= is_query & ~known_query;
            rsp_data_q  <= is_query ? query_value : 8'h00;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            nv_save_q  <= 1'b0;
            nv_image_q <= '0;
        end else begin
            nv_save_q <= is_save;
            if (is_save) begin
                nv_image_q <= setup_q;
            end
        end
    end

    assign o_dac_volt  = dac_volt_q;
    assign o_dac_curr  = dac_curr_q;
    assign o_rsp_valid = rsp_valid_q;
    assign o_rsp_error = rsp_error_q;
    assign o_rsp_data  = rsp_data_q;
    assign o_nv_save   = nv_save_q;
    assign o_nv_image  = nv_image_q;

    property p_off_zero;
        @(posedge i_clk_sys) disable iff (i_reset)
        (!i_output_on && setup_q.select == lds_pkg::SELECT_RESET)
        |=> (o_dac_volt == W'(lds_pkg::DAC_ZERO)) &&
            (o_dac_curr == W'(lds_pkg::DAC_ZERO));
    endproperty
    a_off_zero: assert property (p_off_zero)
        else $error("Off with select zero did not zero both DACs");

    property p_volt_full;
        @(posedge i_clk_sys) disable iff (i_reset)
        (!i_output_on && !i_current_mode &&
         setup_q.select[lds_pkg::SEL_VOLT_FULL_BIT])
        |=> o_dac_volt == W'(lds_pkg::DAC_FULL);
    endproperty
    a_volt_full: assert property (p_volt_full)
        else $error("Voltage DAC not at full scale when off");

    property p_curr_full;
        @(posedge i_clk_sys) disable iff (i_reset)
        (!i_output_on && i_current_mode &&
         setup_q.select[lds_pkg::SEL_CURR_FULL_BIT])
        |=> o_dac_curr == W'(lds_pkg::DAC_FULL);
    endproperty
    a_curr_full: assert property (p_curr_full)
        else $error("Current DAC not at full scale when off");

    property p_volt_off_code;
        @(posedge i_clk_sys) disable iff (i_reset)
        (!i_output_on && setup_q.select[lds_pkg::SEL_VOLT_CODE_BIT] &&
         !(setup_q.select[lds_pkg::SEL_VOLT_FULL_BIT] && !i_current_mode))
        |=> o_dac_volt == $past(setup_q.off_volt);
    endproperty
    a_volt_off_code: assert property (p_volt_off_code)
        else $error("Voltage DAC not at stored off code");

    property p_curr_off_code;
        @(posedge i_clk_sys) disable iff (i_reset)
        (!i_output_on && setup_q.select[lds_pkg::SEL_CURR_CODE_BIT] &&
         !(setup_q.select[lds_pkg::SEL_CURR_FULL_BIT] && i_current_mode))
        |=> o_dac_curr == $past(setup_q.off_curr);
    endproperty
    a_curr_off_code: assert property (p_curr_off_code)
        else $error("Current DAC not at stored off code");

    property p_curr_fixed;
        @(posedge i_clk_sys) disable iff (i_reset)
        (i_output_on && !i_current_mode &&
         setup_q.err_curr[lds_pkg::ERR_FIX_BIT])
        |=> o_dac_curr == $past(setup_q.on_curr);
    endproperty
    a_curr_fixed: assert property (p_curr_fixed)
        else $error("Current DAC not at fixed on code");

    property p_volt_fixed;
        @(posedge i_clk_sys) disable iff (i_reset)
        (i_output_on && i_current_mode &&
         setup_q.err_volt[lds_pkg::ERR_FIX_BIT])
        |=> o_dac_volt == $past(setup_q.on_volt);
    endproperty
    a_volt_fixed: assert property (p_volt_fixed)
        else $error("Voltage DAC not at fixed on code");

    property p_sanitize;
        @(posedge i_clk_sys) disable iff (i_reset)
        is_sanitize |=> (setup_q.select == lds_pkg::SELECT_RESET)
                        && $stable(setup_q.off_curr);
    endproperty
    a_sanitize: assert property (p_sanitize)
        else $error("Sanitize did not clear select only");

    property p_query;
        @(posedge i_clk_sys) disable iff (i_reset)
        (is_query && i_cmd.code == lds_pkg::CMD_ON_VOLT)
        |=> o_rsp_valid && !o_rsp_error &&
            (o_rsp_data == $past(setup_q.on_volt));
    endproperty
    a_query: assert property (p_query)
        else $error("Query answer does not match stored code");

    property p_reset_codes;
        @(posedge i_clk_sys)
        i_reset |=> (setup_q.off_curr == lds_pkg::CODE_RESET) &&
                    (setup_q.off_volt == lds_pkg::CODE_RESET) &&
                    (setup_q.on_curr  == lds_pkg::CODE_RESET) &&
                    (setup_q.on_volt  == lds_pkg::CODE_RESET);
    endproperty
    a_reset_codes: assert property (p_reset_codes)
        else $error("Stored codes not zero after reset");

    property p_save;
        @(posedge i_clk_sys) disable iff (i_reset)
        is_save |=> o_nv_save && (o_nv_image == $past(setup_q))
                ##1 ($stable(o_nv_image) || $past(is_save));
    endproperty
    a_save: assert property (p_save)
        else $error("Save did not copy setup or image did not hold");

    property p_query_err;
        @(posedge i_clk_sys) disable iff (i_reset)
        (is_query && !known_query)
        |=> o_rsp_valid && o_rsp_error && (o_rsp_data == 8'h00);
    endproperty
    a_query_err: assert property (p_query_err)
        else $error("Unknown query not refused");

    property p_select_nibble;
        @(posedge i_clk_sys) disable iff (i_reset)
        (is_write && i_cmd.code == lds_pkg::CMD_SELECT)
        |=> setup_q.select == $past(i_cmd.data[3:0]);
    endproperty
    a_select_nibble: assert property (p_select_nibble)
        else $error("Select write did not keep the low nibble");
endmodule
`default_nettype wire

// ### lds_limit_dac_code_selector_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lds_limit_dac_code_selector_tb;
    logic                clk_sys = 1'b0;
    logic                reset = 1'b1;
    lds_pkg::lds_cmd_t   cmd = '0;
    logic                output_on = 1'b0;
    logic                current_mode = 1'b0;
    logic [7:0]          volt_sp = 8'h00;
    logic [7:0]          curr_sp = 8'h00;
    logic [7:0]          dac_volt;
    logic [7:0]          dac_curr;
    logic                rsp_valid;
    logic                rsp_error;
    logic [7:0]          rsp_data;
    logic                nv_save;
    lds_pkg::lds_setup_t nv_image;
    lds_pkg::lds_setup_t nv_store;
    logic [31:0]         rnd = 32'h5076;
    int                  n_fail = 0;
    int                  total_checks = 0;
    int                  cyc = 0;
    int                  m_reg [7];
    int                  e_v, e_c, e_rd, e_pv, e_pc;
    int                  pm_v, pm_c;
    logic                e_rv, e_re, e_save;
    logic [59:0]         e_img, m_nv_img;

    always #5 clk_sys = ~clk_sys;

    lds_limit_dac_code_selector i_dut (
        .i_clk_sys       (clk_sys),
        .i_reset         (reset),
        .i_cmd           (cmd),
        .i_output_on     (output_on),
        .i_current_mode  (current_mode),
        .i_volt_setpoint (volt_sp),
        .i_curr_setpoint (curr_sp),
        .o_dac_volt      (dac_volt),
        .o_dac_curr      (dac_curr),
        .o_rsp_valid     (rsp_valid),
        .o_rsp_error     (rsp_error),
        .o_rsp_data      (rsp_data),
        .o_nv_save       (nv_save),
        .o_nv_image      (nv_image)
    );

    lds_limit_dac_partner i_far (
        .i_clk_sys       (clk_sys),
        .i_dac_volt      (dac_volt),
        .i_dac_curr      (dac_curr),
        .i_nv_save       (nv_save),
        .i_nv_image      (nv_image),
        .o_volt_permille (pm_v),
        .o_curr_permille (pm_c),
        .o_nv_store      (nv_store)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h00000000);
    endfunction

    function automatic logic [7:0] scale(input int e, input int m);
        return 8'((e * 2560) / (m * 11));
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Reference model, sampled before the bench's updates land
    always @(posedge clk_sys) begin
        if (e_save)
            m_nv_img = e_img;
        // Far side sees the code expected after the previous edge
        e_pv = e_v * 1000 / 255;
        e_pc = e_c * 1000 / 255;
        if (reset) begin
            foreach (m_reg[k]) m_reg[k] = 0;
            {e_v, e_c, e_rd} = '0;
            {e_rv, e_re, e_save, e_img} = '0;
        end else begin
            e_v = !output_on ? ((m_reg[4][0] && !current_mode) ? 255 :
                                 m_reg[4][2] ? m_reg[1] : 0) :
                  ((current_mode && m_reg[6][7]) ? m_reg[3] : int'(volt_sp));
            e_c = !output_on ? ((m_reg[4][1] && current_mode) ? 255 :
                                 m_reg[4][3] ? m_reg[0] : 0) :
                  ((!current_mode && m_reg[5][7]) ? m_reg[2] : int'(curr_sp));
            e_rv = cmd.valid && cmd.query;
            e_re = e_rv && cmd.code > 4'h6;
            e_rd = (e_rv && !e_re) ? m_reg[cmd.code] : 0;
            e_save = cmd.valid && !cmd.query && cmd.code == 4'h8;
            if (e_save)
                e_img = {8'(m_reg[0]), 8'(m_reg[1]), 8'(m_reg[2]),
                         8'(m_reg[3]), 4'(m_reg[4]), 8'(m_reg[5]),
                         8'(m_reg[6])};
            if (cmd.valid && !cmd.query) begin
                if (cmd.code == 4'h4)
                    m_reg[4] = int'(cmd.data[3:0]);
                else if (cmd.code < 4'h7)
                    m_reg[cmd.code] = int'(cmd.data);
                else if (cmd.code == 4'h7)
                    m_reg[4] = 0;
            end
        end
        #1;
        check(64'(dac_volt), 64'(e_v));
        check(64'(dac_curr), 64'(e_c));
        check(64'(pm_v), 64'(e_pv));
        check(64'(pm_c), 64'(e_pc));
        check(64'(rsp_valid), 64'(e_rv));
        check(64'(rsp_error), 64'(e_re));
        check(64'(rsp_data), 64'(e_rd));
        check(64'(nv_save), 64'(e_save));
        check(64'(nv_image), 64'(e_img));
        check(64'(nv_store), 64'(m_nv_img));
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic drive_random(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            rnd = lfsr(rnd);
            if (rnd[7:4] == 4'h0)
                output_on <= ~output_on;
            if (rnd[11:8] == 4'h0)
                current_mode <= ~current_mode;
            volt_sp <= rnd[23:16];
            curr_sp <= scale(int'(rnd[31:24]), 255);
            cmd <= {rnd[0], rnd[1] & rnd[2], rnd[15:12], rnd[31:24]};
        end
    endtask

    initial begin
        m_nv_img = '0;
        e_save = 1'b0;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        // Factory defaults of every place, back to back
        for (int k = 0; k < 16; k++) begin
            @(posedge clk_sys);
            cmd <= {1'b1, 1'b1, 4'(k), 8'h00};
        end
        drive_random(4000);
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        drive_random(3000);
        @(posedge clk_sys);
        cmd <= '0;
        repeat (3) @(posedge clk_sys);
        stop_test();
    end
endmodule
`default_nettype wire

// ### lds_limit_dac_partner.sv
`timescale 1ns/1ps
`default_nettype none
module lds_limit_dac_partner (
    input  wire logic                i_clk_sys,
    input  wire logic [7:0]          i_dac_volt,
    input  wire logic [7:0]          i_dac_curr,
    input  wire logic                i_nv_save,
    input  wire lds_pkg::lds_setup_t i_nv_image,
    output int                       o_volt_permille,
    output int                       o_curr_permille,
    output lds_pkg::lds_setup_t      o_nv_store
);
    // Store is nonvolatile, so no reset clears it
    initial o_nv_store = '0;
    always @(posedge i_clk_sys) begin
        o_volt_permille <= (int'(i_dac_volt) * 1000) / 255;
        o_curr_permille <= (int'(i_dac_curr) * 1000) / 255;
        if (i_nv_save === 1'b1)
            o_nv_store <= i_nv_image;
    end
endmodule
`default_nettype wire

// ### lds_pkg.sv
package lds_pkg;
    // Limit DAC code width and the two fixed codes
    localparam int         CODE_W    = 8;
    localparam logic [7:0] DAC_ZERO  = 8'h00;
    localparam logic [7:0] DAC_FULL  = 8'hff;

    // Command codes on the host command port
    localparam logic [3:0] CMD_OFF_CURR = 4'h0;
    localparam logic [3:0] CMD_OFF_VOLT = 4'h1;
    localparam logic [3:0] CMD_ON_CURR  = 4'h2;
    localparam logic [3:0] CMD_ON_VOLT  = 4'h3;
    localparam logic [3:0] CMD_SELECT   = 4'h4;
    localparam logic [3:0] CMD_ERR_CURR = 4'h5;
    localparam logic [3:0] CMD_ERR_VOLT = 4'h6;
    localparam logic [3:0] CMD_SANITIZE = 4'h7;
    localparam logic [3:0] CMD_SAVE     = 4'h8;

    // Off-state select field positions
    localparam int SEL_VOLT_FULL_BIT = 0;
    localparam int SEL_CURR_FULL_BIT = 1;
    localparam int SEL_VOLT_CODE_BIT = 2;
    localparam int SEL_CURR_CODE_BIT = 3;
    // Error configuration: fixed on-state limit enable
    localparam int ERR_FIX_BIT       = 7;

    // Factory defaults
    localparam logic [7:0] CODE_RESET   = 8'h00;
    localparam logic [3:0] SELECT_RESET = 4'h0;
    localparam logic [7:0] ERR_RESET    = 8'h00;
    localparam logic [3:0] NIBBLE_ZERO  = 4'h0;

    typedef struct packed {
        logic       valid;
        logic       query;
        logic [3:0] code;
        logic [7:0] data;
    } lds_cmd_t;

    typedef struct packed {
        logic [7:0] off_curr;
        logic [7:0] off_volt;
        logic [7:0] on_curr;
        logic [7:0] on_volt;
        logic [3:0] select;
        logic [7:0] err_curr;
        logic [7:0] err_volt;
    } lds_setup_t;
endpackage
